// [hdl/event_snapshot_readout.sv]
// Purpose: management-bus command logic for averaging coefficient and fault snapshot read-out
// Assumes: command port is decoded upstream from the bus framing; one command per cycle
// Notes:   answers come one cycle after the command; whole record is returned at once
//
// Summary of operation
// - six-bit coefficient, zero disables current averaging
// - event read returns snapshot chosen by index
// - vout at 47:32, vin at 31:16
// - nack event reads unless enabled or monitor mode
// - duty field holds target duty while enabled
// - ticks low in top bits, high byte below
// - old state is state 4 to 8 ms earlier
// - error state is state at error detection
`timescale 1ns/1ps
`include "snapshot_defs.svh"
module event_snapshot_readout
  import snapshot_pkg::*;
#(
  parameter int unsigned OLD_STATE_CYCLES = `OLD_STATE_MS * 1000 * `CLK_MHZ  // state history period
)(
  input  wire logic                 clk,             // system clock, 100 MHz
  input  wire logic                 sys_rst,         // async reset, active high
  input  wire logic                 cmd_valid,       // command strobe, one cycle
  input  wire logic                 cmd_read,        // 1 read, 0 write
  input  wire logic [7:0]           cmd_code,        // command code
  input  wire logic [7:0]           cmd_wdata,       // write data byte
  output logic                      rsp_valid,       // answer strobe, one cycle
  output logic                      rsp_nack,        // answer refused
  output logic      [`REC_W-1:0]    rsp_data,        // read data, low bits for short items
  input  wire logic                 event_capture,   // fault detected, one-cycle pulse
  input  wire logic [3:0]           ctrl_state,      // current controller state
  input  wire logic [15:0]          vin,             // input voltage reading
  input  wire logic [15:0]          vout,            // output voltage reading
  input  wire logic [15:0]          iout,            // output current reading
  input  wire logic [15:0]          temp,            // temperature reading
  input  wire logic [15:0]          target_duty,     // target duty cycle, percent
  input  wire logic                 mfr_bit5,        // mfr specific status bit 5
  input  wire logic                 invalid_cmd,     // invalid command status bit
  input  wire logic                 output_enabled,  // converter in enabled state
  input  wire logic                 monitor_mode,    // user-config monitor mode active
  output logic      [`COEFF_W-1:0]  avg_coeff,       // averaging coefficient
  output logic                      avg_enable       // averaging and average limit active
);
  localparam int unsigned TMR_W = 20;
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(OLD_STATE_CYCLES - 1);

  logic [`COEFF_W-1:0]    coeff_q;          // coefficient register
  logic                   avg_en_q;         // registered enable
  logic [`SNAP_SEL_W-1:0] sel_q;            // selected snapshot
  logic [39:0]            tick_q;           // free-running tick count
  logic [TMR_W-1:0]       tmr_q;            // history period timer
  logic [3:0]             hist0_q;          // state sampled last period
  logic [3:0]             hist1_q;          // state sampled the period before
  logic [15:0]            duty_q;           // duty held from the enabled state
  logic [15:0]            id_q;             // next event identifier
  logic                   rsp_valid_q;
  logic                   rsp_nack_q;
  logic [`REC_W-1:0]      rsp_data_q;
  logic [`REC_W-1:0]      rsp_data_d;
  logic                   rsp_nack_d;
  logic [`REC_W-1:0]      rec;              // record being captured
  logic [`REC_W-1:0]      rd_rec;           // record selected for read
  logic [`SNAP_CNT_W-1:0] snap_cnt;         // records held

  // command decode
  wire is_coeff = cmd_code == `CMD_AVG_COEFF;
  wire is_index = cmd_code == `CMD_EVENT_INDEX;
  wire is_event = cmd_code == `CMD_READ_EVENT;
  wire wr_coeff = cmd_valid && !cmd_read && is_coeff;
  wire wr_index = cmd_valid && !cmd_read && is_index;
  // duty and current items are only valid while running or monitoring
  wire live_ok  = output_enabled || monitor_mode;
  wire tmr_wrap = tmr_q == TMR_LAST;

  // answer selection; unknown codes are refused
  // the record is read-only, so a write to it is refused like an unknown code
  wire known_code = is_coeff || is_index || is_event;  // code this block answers
  wire ev_write   = is_event && !cmd_read;             // write aimed at the record
  // whole record refused, since duty and current items are not addressable alone
  wire ev_idle    = is_event && cmd_read && !live_ok;
  assign rsp_nack_d = !known_code || ev_write || ev_idle;
  assign rsp_data_d = !cmd_read ? '0 :
                      is_coeff  ? `REC_W'(coeff_q) :
                      is_index  ? `REC_W'({sel_q, 4'h0, snap_cnt}) :
                      (is_event && live_ok) ? rd_rec : '0;

  // record assembly, fields at fixed bit positions
  assign rec = {tick_q[31:0],
                tick_q[39:32],
                hist1_q,
                ctrl_state,
                3'h0, mfr_bit5, 4'h0, invalid_cmd, 55'h0,
                duty_q,
                temp, iout,
                vout, vin,
                id_q};

  // coefficient and selection registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      coeff_q  <= `COEFF_RESET;
      avg_en_q <= 1'b0;
      sel_q    <= '0;
    end else begin
      if (wr_coeff) begin
        coeff_q  <= cmd_wdata[`COEFF_W-1:0];
        avg_en_q <= cmd_wdata[`COEFF_W-1:0] != '0;
      end
      if (wr_index) begin
        sel_q <= cmd_wdata[`SNAP_SEL_W-1:0];
      end
    end
  end

  // tick count and state history; history age spans one to two periods
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_q  <= '0;
      tmr_q   <= '0;
      hist0_q <= CST_IDLE;
      hist1_q <= CST_IDLE;
    end else begin
      tick_q <= tick_q + 40'h1;
      tmr_q  <= tmr_wrap ? '0 : tmr_q + TMR_W'(1);
      if (tmr_wrap) begin
        hist0_q <= ctrl_state;
        hist1_q <= hist0_q;
      end
    end
  end

  // duty latch and event identifier
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty_q <= '0;
      id_q   <= '0;
    end else begin
      if (output_enabled) begin
        duty_q <= target_duty;
      end
      if (event_capture) begin
        id_q <= id_q + 16'h1;
      end
    end
  end

  // answer registers, every output straight from a flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_nack_q  <= 1'b0;
      rsp_data_q  <= '0;
    end else begin
      rsp_valid_q <= cmd_valid;
      rsp_nack_q  <= cmd_valid && rsp_nack_d;
      rsp_data_q  <= cmd_valid ? rsp_data_d : '0;
    end
  end

  assign rsp_valid  = rsp_valid_q;
  assign rsp_nack   = rsp_nack_q;
  assign rsp_data   = rsp_data_q;
  assign avg_coeff  = coeff_q;
  assign avg_enable = avg_en_q;

  // snapshot memory
  snapshot_store u_store (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (event_capture),
    .wr_data (rec),
    .rd_sel  (sel_q),
    .rd_data (rd_rec),
    .count   (snap_cnt)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  coeff_store_a: assert property (wr_coeff |=> avg_coeff == $past(cmd_wdata[5:0]))
    else $error("coefficient not stored");
  avg_gate_a: assert property (wr_coeff |=> avg_enable == ($past(cmd_wdata[5:0]) != 6'h00))
    else $error("averaging enable wrong");
  event_read_a: assert property (cmd_valid && cmd_read && is_event && live_ok
                                 |=> !rsp_nack && rsp_data == $past(rd_rec))
    else $error("event read not the selected record");
  field_volt_a: assert property (rec[47:32] == vout && rec[31:16] == vin)
    else $error("voltage fields misplaced");
  live_nack_a: assert property (cmd_valid && is_event && !live_ok |=> rsp_valid && rsp_nack)
    else $error("event read not refused");
  duty_hold_a: assert property (!output_enabled |=> $stable(duty_q) && rec[95:80] == duty_q)
    else $error("duty changed while disabled");
  tick_split_a: assert property (rec[207:176] == tick_q[31:0] && rec[175:168] == tick_q[39:32])
    else $error("tick fields misplaced");
  old_state_a: assert property (tmr_wrap |=> hist1_q == $past(hist0_q) ##1 rec[167:164] == hist1_q)
    else $error("old state not shifted");
  err_state_a: assert property (rec[163:160] == ctrl_state)
    else $error("error state wrong");
  event_id_a: assert property (event_capture |=> id_q == $past(id_q) + 16'h1 && rec[15:0] == id_q)
    else $error("event id not advanced");

  // every command is answered in the very next cycle, and only then
  answer_slot_a: assert property (rsp_valid == $past(cmd_valid))
    else $error("answer out of its slot");
  // the index write picks the record that later event reads return
  index_sel_a: assert property (wr_index |=> sel_q == $past(cmd_wdata[2:0]))
    else $error("snapshot selection not stored");
  // the record can only be read; a write must come back refused
  record_write_a: assert property (cmd_valid && is_event && !cmd_read |=> rsp_valid && rsp_nack)
    else $error("write to the record not refused");
  // a refused answer must not leak any record contents
  nack_clear_a: assert property (rsp_nack |-> rsp_valid && rsp_data == '0)
    else $error("refused answer carries data");
  // duty follows the target while enabled, so the record holds the enabled value
  duty_track_a: assert property (output_enabled |=> duty_q == $past(target_duty))
    else $error("duty not taken while enabled");
  // coefficient read-back returns the stored value, zero-extended
  coeff_read_a: assert property (cmd_valid && cmd_read && is_coeff |=> !rsp_nack && rsp_data == `REC_W'($past(coeff_q)))
    else $error("coefficient read-back wrong");

  coeff_wr_c: cover property (wr_coeff ##1 avg_enable);
  event_ok_c: cover property (cmd_valid && cmd_read && is_event && live_ok && snap_cnt != '0);
  event_nack_c: cover property (cmd_valid && is_event && !live_ok ##1 rsp_nack);
  capture_c: cover property (event_capture ##1 event_capture);
endmodule

// [hdl/snapshot_defs.svh]
// Purpose: constants for the snapshot read-out and averaging-coefficient command logic
// Assumes: 100 MHz clock, commands arrive one per cycle at most
// Notes:   offsets are management-bus command codes; field positions are record bit numbers
`ifndef SNAPSHOT_DEFS_SVH
`define SNAPSHOT_DEFS_SVH

// command codes
`define CMD_AVG_COEFF     8'hD2
`define CMD_EVENT_INDEX   8'hD6
`define CMD_READ_EVENT    8'hD7

// averaging coefficient
`define COEFF_W           6
`define COEFF_RESET       6'h00

// record layout
`define REC_W             208
`define F_TICKLO_HI       207
`define F_TICKLO_LO       176
`define F_TICKHI_HI       175
`define F_TICKHI_LO       168
`define F_OLD_HI          167
`define F_OLD_LO          164
`define F_ERR_HI          163
`define F_ERR_LO          160
`define F_MFR5            156
`define F_INVCMD          151
`define F_DUTY_HI         95
`define F_DUTY_LO         80
`define F_TEMP_HI         79
`define F_TEMP_LO         64
`define F_IOUT_HI         63
`define F_IOUT_LO         48
`define F_VOUT_HI         47
`define F_VOUT_LO         32
`define F_VIN_HI          31
`define F_VIN_LO          16
`define F_ID_HI           15
`define F_ID_LO           0

// snapshot store
`define SNAP_DEPTH        8
`define SNAP_SEL_W        3
`define SNAP_CNT_W        4

// timing: old state age
`define CLK_MHZ           100
`define OLD_STATE_MS      4

`endif

// [hdl/snapshot_pkg.sv]
// Purpose: shared types for the snapshot read-out block
// Assumes: controller state codes are four bits wide
// Notes:   codes 0111 and above are never produced by the controller
package snapshot_pkg;
  typedef enum logic [3:0] {
    CST_IDLE       = 4'h0,
    CST_TON_DELAY  = 4'h1,
    CST_RAMP_UP    = 4'h2,
    CST_REGULATING = 4'h3,
    CST_TOFF_DELAY = 4'h4,
    CST_RAMP_DOWN  = 4'h5,
    CST_FAULT      = 4'h6
  } ctrl_state_e;
  typedef logic [15:0] word_t;
endpackage

// [hdl/snapshot_store.sv]
// Purpose: write-once store of fault snapshot records with indexed read
// Assumes: wr_en is a one-cycle pulse per fault event
// Notes:   once full, further events are dropped, like a one-time memory
`timescale 1ns/1ps
`include "snapshot_defs.svh"
module snapshot_store
  import snapshot_pkg::*;
(
  input  wire logic                    clk,      // system clock
  input  wire logic                    sys_rst,  // async reset, active high
  input  wire logic                    wr_en,    // store one record
  input  wire logic [`REC_W-1:0]       wr_data,  // record to store
  input  wire logic [`SNAP_SEL_W-1:0]  rd_sel,   // selected record
  output logic      [`REC_W-1:0]       rd_data,  // selected record, zero if empty slot
  output logic      [`SNAP_CNT_W-1:0]  count     // records held
);
  logic [`REC_W-1:0]      mem [`SNAP_DEPTH];  // record array, no reset needed
  logic [`SNAP_CNT_W-1:0] count_q;            // fill level
  logic [`SNAP_CNT_W-1:0] count_d;
  wire                    full;               // no free slot
  wire                    do_wr;              // accepted write
  wire                    sel_valid;          // selected slot holds data

  assign full      = (count_q == `SNAP_CNT_W'(`SNAP_DEPTH));
  assign do_wr     = wr_en && !full;
  assign count_d   = do_wr ? count_q + `SNAP_CNT_W'(1) : count_q;
  assign sel_valid = ({1'b0, rd_sel} < count_q);
  // empty slots read as zero so stale array contents never leak out
  assign rd_data   = sel_valid ? mem[rd_sel] : '0;
  assign count     = count_q;

  // fill level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // record write at the next free slot
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[count_q[`SNAP_SEL_W-1:0]] <= wr_data;
    end
  end
endmodule

// [tb/host_model.sv]
// Purpose: bus host model issuing one command at a time and collecting the answer
// Assumes: the answer comes exactly one cycle after the command is taken
// Notes:   released code and data lines show the inverse of the last value
`timescale 1ns/1ps
`include "snapshot_defs.svh"
module host_model (
  input  wire logic               clk,        // system clock
  output logic                    cmd_valid,  // command strobe
  output logic                    cmd_read,   // 1 read, 0 write
  output logic      [7:0]         cmd_code,   // command code
  output logic      [7:0]         cmd_wdata,  // write byte
  input  wire logic               rsp_valid,  // answer strobe
  input  wire logic               rsp_nack,   // answer refused
  input  wire logic [`REC_W-1:0]  rsp_data    // answer data
);
  // idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_read  = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 8'h00;
  end

  // one command; ok is low if the answer misses its one-cycle slot
  task automatic xfer(input logic r, input logic [7:0] c, input logic [7:0] w,
                      output logic nk, output logic [`REC_W-1:0] d, output logic ok);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read  <= r;
    cmd_code  <= c;
    cmd_wdata <= w;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;  // stale code must never look valid
    cmd_wdata <= ~w;
    // the answer stands between the taking edge and the next; look mid-cycle, off both edges
    @(negedge clk);
    ok = (rsp_valid === 1'b1);
    nk = rsp_nack;
    d  = rsp_data;
  endtask
endmodule

// [tb/tb_event_snapshot_readout.sv]
// Purpose: self-checking bench for coefficient and snapshot read-out commands
// Assumes: short history period so the old state settles quickly
// Notes:   ticks are checked by difference, since absolute count depends on reset timing
`timescale 1ns/1ps
`include "snapshot_defs.svh"
module tb_event_snapshot_readout;
  import snapshot_pkg::*;
  localparam int unsigned HIST = 8;  // shortened history period
  logic clk = 1'b0;
  logic sys_rst, cmd_valid, cmd_read, rsp_valid, rsp_nack, event_capture;
  logic mfr_bit5, invalid_cmd, output_enabled, monitor_mode, avg_enable, nk, ok;
  logic [7:0]        cmd_code, cmd_wdata;
  logic [`REC_W-1:0] rsp_data, rd;
  logic [3:0]        ctrl_state;
  logic [15:0]       vin, vout, iout, temp, target_duty;
  logic [5:0]        avg_coeff;
  logic [31:0]       t0;          // tick of first record
  int                bad_count = 0;
  int                cmp_count = 0;

  always #5 clk = ~clk;  // 100 MHz

  host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_data(rsp_data));

  event_snapshot_readout #(.OLD_STATE_CYCLES(HIST)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_data(rsp_data), .event_capture(event_capture),
    .ctrl_state(ctrl_state), .vin(vin), .vout(vout), .iout(iout), .temp(temp),
    .target_duty(target_duty), .mfr_bit5(mfr_bit5), .invalid_cmd(invalid_cmd),
    .output_enabled(output_enabled), .monitor_mode(monitor_mode), .avg_coeff(avg_coeff),
    .avg_enable(avg_enable));

  // compare and report
  task automatic chk(input logic [`REC_W-1:0] got, input logic [`REC_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one command, answer must arrive in its slot
  task automatic cmd(input logic r, input logic [7:0] c, input logic [7:0] w);
    u_host.xfer(r, c, w, nk, rd, ok);
    chk(ok, 1'b1);
  endtask

  // one capture pulse
  task automatic cap();
    @(posedge clk);
    event_capture <= 1'b1;
    @(posedge clk);
    event_capture <= 1'b0;
  endtask

  // coefficient boundaries, upper write bits ignored
  task automatic t_coeff();
    logic [7:0] wv [5] = '{8'h00, 8'h01, 8'h3F, 8'hFF, 8'h40};
    foreach (wv[i]) begin
      cmd(1'b0, `CMD_AVG_COEFF, wv[i]);
      chk(nk, 1'b0);
      chk(avg_coeff, wv[i][5:0]);
      chk(avg_enable, wv[i][5:0] != 6'h00);
      cmd(1'b1, `CMD_AVG_COEFF, 8'h00);
      chk(rd, wv[i][5:0]);
    end
  endtask

  // two records, field layout and tick spacing
  task automatic t_rec();
    @(posedge clk);
    {ctrl_state, output_enabled, target_duty} <= {CST_REGULATING, 1'b1, 16'h0032};
    {vin, vout, iout, temp} <= {16'hA1B2, 16'hC3D4, 16'h8001, 16'hFFEE};
    {mfr_bit5, invalid_cmd} <= 2'b11;
    repeat (4 * HIST) @(posedge clk);
    ctrl_state <= CST_FAULT;
    cap();
    repeat (3) @(posedge clk);
    cap();
    cmd(1'b1, `CMD_EVENT_INDEX, 8'h00);
    chk(rd[14:0], 15'h0002);
    cmd(1'b0, `CMD_EVENT_INDEX, 8'h00);
    cmd(1'b1, `CMD_READ_EVENT, 8'h00);
    chk(nk, 1'b0);
    chk(rd[167:0], {CST_REGULATING, CST_FAULT, 3'h0, 1'b1, 4'h0, 1'b1, 55'h0, 16'h0032,
      16'hFFEE, 16'h8001, 16'hC3D4, 16'hA1B2, 16'h0000});
    t0 = rd[207:176];
    chk(rd[175:168], 8'h00);
    cmd(1'b0, `CMD_EVENT_INDEX, 8'h01);
    cmd(1'b1, `CMD_READ_EVENT, 8'h00);
    chk(rd[15:0], 16'h0001);
    chk(rd[207:176] - t0, 32'd5);
  endtask

  // refusals while disabled, monitor mode lifts them; unknown codes and record writes refused
  task automatic t_nack();
    @(posedge clk);
    output_enabled <= 1'b0;
    cmd(1'b1, `CMD_READ_EVENT, 8'h00);
    chk(nk, 1'b1);
    chk(rd, 208'h0);
    @(posedge clk);
    monitor_mode <= 1'b1;
    cmd(1'b1, `CMD_READ_EVENT, 8'h00);
    chk({nk, rd[15:0]}, {1'b0, 16'h0001});
    cmd(1'b0, `CMD_READ_EVENT, 8'h00);
    chk(nk, 1'b1);
    cmd(1'b1, 8'h00, 8'h00);
    chk(nk, 1'b1);
    chk(rd, 208'h0);
    cmd(1'b0, `CMD_EVENT_INDEX, 8'h07);
    cmd(1'b1, `CMD_EVENT_INDEX, 8'h00);
    chk(rd[14:0], 15'h0702);
    cmd(1'b1, `CMD_READ_EVENT, 8'h00);
    chk(nk, 1'b0);
    chk(rd, 208'h0);
  endtask

  // counts and verdict, then stop
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence; every input defined at time zero
  initial begin
    {sys_rst, event_capture, mfr_bit5, invalid_cmd, output_enabled, monitor_mode} = 6'b100000;
    {ctrl_state, vin, vout, iout, temp, target_duty} = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_coeff();
    t_rec();
    t_nack();
    print_verdict();
  end

  // watchdog, well beyond the hundred or so cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
